// [logic/cnh_top.sv]
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module cnh_top #(
  parameter int MBX_WORDS = cnh_pkg::MBX_WORDS,
  parameter int MBX_COUNT = cnh_pkg::MBX_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_store_i,
  input wire logic [1:0] rx_mbx_i,
  input wire logic [31:0] rx_word_i,
  output logic rx_store_done_o,
  output logic core_clk_en_o,
  output logic comm_rst_o,
  output logic dtc_req_o,
  output logic irq_o
);
  localparam int NW = MBX_WORDS * MBX_COUNT;
  localparam int AW = $clog2(NW);
  localparam int WB = $clog2(MBX_WORDS);

  typedef enum logic [1:0] {CNH_IDLE, CNH_WAIT, CNH_RESP} cnh_bus_e;

  logic stop_q;
  logic [31:0] mcr_q;
  logic [2:0] irr_q;
  logic [2:0] imr_q;
  logic ctl_rst;
  logic sleep;
  logic [AW-1:0] rx_ptr_q;
  logic rx_busy_q;
  logic [2:0] wcnt_q;
  cnh_bus_e wst_q;
  cnh_bus_e rst_q;
  logic aw_got_q;
  logic w_got_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [11:0] araddr_q;
  logic ram_we;
  logic [AW-1:0] ram_waddr;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;
  logic rd_mbx_q;
  logic [31:0] rd_reg_q;
  logic mb0_rx_evt;
  logic refused_w;
  logic refused_r;

  function automatic logic is_mbx(input logic [11:0] a);
    is_mbx = (a >= cnh_pkg::MBX_BASE) && (a < cnh_pkg::MBX_BASE + 12'(NW * 4));
  endfunction

  function automatic logic [AW-1:0] mbx_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - cnh_pkg::MBX_BASE;
    mbx_idx = off[AW+1:2];
  endfunction

  // only control registers reachable in sleep
  function automatic logic sleep_ok(input logic [11:0] a);
    sleep_ok = (a == cnh_pkg::STBCR_OFS) || (a == cnh_pkg::MCR_OFS) || (a == cnh_pkg::GSR_OFS)
      || (a == cnh_pkg::IRR_OFS) || (a == cnh_pkg::IMR_OFS);
  endfunction

  assign ctl_rst = srst_i || stop_q || mcr_q[cnh_pkg::MCR_SOFT_RESET_BIT];
  assign sleep = mcr_q[cnh_pkg::MCR_SLEEP_BIT];

  logic wr_fire;
  assign wr_fire = (wst_q == CNH_WAIT);
  logic w_busy_mbx;
  assign w_busy_mbx = is_mbx(awaddr_q) && rx_busy_q && (wcnt_q != 3'(cnh_pkg::STORE_WAIT_MAX));
  assign refused_w = wr_fire && !w_busy_mbx && ((stop_q && awaddr_q != cnh_pkg::STBCR_OFS)
    || (sleep && !sleep_ok(awaddr_q)));
  assign refused_r = (rst_q == CNH_WAIT) && ((stop_q && araddr_q != cnh_pkg::STBCR_OFS)
    || (sleep && !sleep_ok(araddr_q)));

  // module stop, released through standby control
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stop_q <= cnh_pkg::STBCR_RESET[cnh_pkg::STBCR_STOP_BIT];
    end else if (wr_fire && !w_busy_mbx && awaddr_q == cnh_pkg::STBCR_OFS) begin
      stop_q <= wdata_q[cnh_pkg::STBCR_STOP_BIT];
    end
  end

  // soft reset bit survives its own reset
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || stop_q) begin
      mcr_q <= cnh_pkg::MCR_RESET;
    end else if (wr_fire && !refused_w && !w_busy_mbx && awaddr_q == cnh_pkg::MCR_OFS) begin
      mcr_q <= wdata_q;
    end else if (mcr_q[cnh_pkg::MCR_SOFT_RESET_BIT]) begin
      mcr_q <= cnh_pkg::MCR_RESET | 32'h0000_0001;
    end
  end

  // reset sets the reset/config flag; set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (ctl_rst) begin
      irr_q <= 3'b001;
    end else begin
      if (wr_fire && !refused_w && !w_busy_mbx && awaddr_q == cnh_pkg::IRR_OFS) begin
        irr_q <= (irr_q & ~wdata_q[2:0]) | {refused_w | refused_r, mb0_rx_evt, 1'b0};
      end else begin
        irr_q <= irr_q | {refused_w | refused_r, mb0_rx_evt, 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (ctl_rst) begin
      imr_q <= cnh_pkg::IMR_RESET[2:0];
    end else if (wr_fire && !refused_w && !w_busy_mbx && awaddr_q == cnh_pkg::IMR_OFS) begin
      imr_q <= wdata_q[2:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irr_q & imr_q);
    end
  end

  // core clock enable drops in sleep or stop
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_clk_en_o <= 1'b0;
      comm_rst_o <= 1'b1;
    end else begin
      core_clk_en_o <= !stop_q && !sleep;
      comm_rst_o <= ctl_rst;
    end
  end

  // receive store: one word per cycle into the chosen mailbox
  assign mb0_rx_evt = rx_busy_q && (rx_ptr_q[WB-1:0] == WB'(MBX_WORDS - 1)) && (rx_ptr_q[AW-1:WB] == '0);
  always_ff @(posedge ref_clk_i) begin
    if (ctl_rst || sleep) begin
      rx_busy_q <= 1'b0;
      rx_ptr_q <= '0;
      rx_store_done_o <= 1'b0;
    end else begin
      rx_store_done_o <= 1'b0;
      if (!rx_busy_q && rx_store_i) begin
        rx_busy_q <= 1'b1;
        rx_ptr_q <= {(AW-WB)'(rx_mbx_i), WB'(0)};
      end else if (rx_busy_q) begin
        rx_ptr_q <= rx_ptr_q + AW'(1);
        if (rx_ptr_q[WB-1:0] == WB'(MBX_WORDS - 1)) begin
          rx_busy_q <= 1'b0;
          rx_store_done_o <= 1'b1;
        end
      end
    end
  end

  // mailbox 0 receive triggers transfer controller
  always_ff @(posedge ref_clk_i) begin
    if (ctl_rst) begin
      dtc_req_o <= 1'b0;
    end else begin
      dtc_req_o <= mb0_rx_evt && imr_q[cnh_pkg::IRR_MB0_RX_BIT];
    end
  end

  // wait counter caps bus stall at five cycles
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !rx_busy_q) begin
      wcnt_q <= 3'h0;
    end else if (((wst_q == CNH_WAIT) && is_mbx(awaddr_q)) || ((rst_q == CNH_WAIT) && is_mbx(araddr_q))) begin
      if (wcnt_q != 3'(cnh_pkg::STORE_WAIT_MAX)) begin
        wcnt_q <= wcnt_q + 3'h1;
      end
    end
  end

  // reset writes only message control one of each mailbox
  logic [AW-1:0] clr_ptr_q;
  logic clr_act_q;
  always_ff @(posedge ref_clk_i) begin
    if (ctl_rst) begin
      clr_act_q <= 1'b1;
      clr_ptr_q <= '0;
    end else if (clr_act_q) begin
      clr_ptr_q <= clr_ptr_q + AW'(MBX_WORDS);
      if (clr_ptr_q[AW-1:WB] == (AW-WB)'(MBX_COUNT - 1)) begin
        clr_act_q <= 1'b0;
      end
    end
  end

  always_comb begin
    ram_we = 1'b0;
    ram_waddr = mbx_idx(awaddr_q);
    ram_wdata = wdata_q;
    if (clr_act_q) begin
      ram_we = 1'b1;
      ram_waddr = clr_ptr_q | AW'(MBX_WORDS - 1);
      ram_wdata = cnh_pkg::CTRL1_RESET;
    end else if (rx_busy_q) begin
      ram_we = 1'b1;
      ram_waddr = rx_ptr_q;
      ram_wdata = rx_word_i;
    end else if (wr_fire && !refused_w && is_mbx(awaddr_q)) begin
      ram_we = 1'b1;
    end
  end

  cnh_mbx_ram #(.DEPTH(NW), .AW(AW)) u_ram (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(mbx_idx(araddr_q)),
    .rdata_o(ram_rdata)
  );

  // write channel
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wst_q <= CNH_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cnh_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
    end else begin
      unique case (wst_q)
        CNH_IDLE: begin
          s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
          end
          if ((aw_got_q || (s_axi_awvalid && s_axi_awready)) && (w_got_q || (s_axi_wvalid && s_axi_wready))) begin
            wst_q <= CNH_WAIT;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
          end
        end
        CNH_WAIT: begin
          // a refused write never waits: in stop the clear walk is held active
          if (refused_w || !(is_mbx(awaddr_q) && (clr_act_q || w_busy_mbx))) begin
            wst_q <= CNH_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= refused_w ? cnh_pkg::RESP_SLVERR : cnh_pkg::RESP_OKAY;
          end
        end
        CNH_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wst_q <= CNH_IDLE;
          end
        end
      endcase
    end
  end

  // read channel
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rst_q <= CNH_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cnh_pkg::RESP_OKAY;
      araddr_q <= '0;
      rd_mbx_q <= 1'b0;
    end else begin
      unique case (rst_q)
        CNH_IDLE: begin
          s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
          if (s_axi_arvalid && s_axi_arready) begin
            araddr_q <= {s_axi_araddr[11:2], 2'b00};
            rst_q <= CNH_WAIT;
            s_axi_arready <= 1'b0;
          end
        end
        CNH_WAIT: begin
          if (refused_r) begin
            s_axi_rdata <= '0;
            s_axi_rresp <= cnh_pkg::RESP_SLVERR;
            s_axi_rvalid <= 1'b1;
            rst_q <= CNH_RESP;
          end else if (is_mbx(araddr_q)) begin
            if (rd_mbx_q) begin
              s_axi_rdata <= ram_rdata;
              s_axi_rresp <= cnh_pkg::RESP_OKAY;
              s_axi_rvalid <= 1'b1;
              rd_mbx_q <= 1'b0;
              rst_q <= CNH_RESP;
            end else if (!(rx_busy_q && wcnt_q != 3'(cnh_pkg::STORE_WAIT_MAX))) begin
              rd_mbx_q <= 1'b1;
            end
          end else begin
            s_axi_rdata <= rd_reg_q;
            s_axi_rresp <= (araddr_q <= cnh_pkg::IMR_OFS) ? cnh_pkg::RESP_OKAY : cnh_pkg::RESP_SLVERR;
            s_axi_rvalid <= 1'b1;
            rst_q <= CNH_RESP;
          end
        end
        CNH_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_q <= CNH_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    rd_reg_q = 32'h0000_0000;
    unique case (araddr_q)
      cnh_pkg::STBCR_OFS: rd_reg_q = {31'h0, stop_q};
      cnh_pkg::MCR_OFS: rd_reg_q = mcr_q;
      cnh_pkg::GSR_OFS: rd_reg_q = {28'h0, clr_act_q, sleep, rx_busy_q, stop_q};
      cnh_pkg::IRR_OFS: rd_reg_q = {29'h0, irr_q};
      cnh_pkg::IMR_OFS: rd_reg_q = {29'h0, imr_q};
      default: rd_reg_q = 32'h0000_0000;
    endcase
  end

  // assertions
  // out of reset the core clock stays off
  a_stop_gates_clk: assert property (@(posedge ref_clk_i) disable iff (srst_i) stop_q |=> !core_clk_en_o)
    else $error("core clock enabled in module stop");
  a_stop_resets: assert property (@(posedge ref_clk_i) disable iff (srst_i) stop_q |=> irr_q[0] && imr_q == 3'h0)
    else $error("stop did not reset registers");
  a_soft_rst_scope: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    mcr_q[0] && !stop_q |=> imr_q == 3'h0 && comm_rst_o)
    else $error("soft reset scope wrong");
  a_reset_flag_set: assert property (@(posedge ref_clk_i) disable iff (srst_i) ctl_rst |=> irr_q[0])
    else $error("reset flag not set");
  // clear walk touches only control one
  a_ctrl1_only: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    clr_act_q |-> ram_waddr[WB-1:0] == WB'(MBX_WORDS - 1))
    else $error("reset touched mailbox data");
  a_sleep_gates: assert property (@(posedge ref_clk_i) disable iff (srst_i) sleep |=> !core_clk_en_o)
    else $error("core clock running in sleep");
  a_wait_bound: assert property (@(posedge ref_clk_i) disable iff (srst_i || ctl_rst)
    (rst_q == CNH_WAIT) && is_mbx(araddr_q) && !refused_r && !clr_act_q |-> ##[1:8] s_axi_rvalid)
    else $error("mailbox read wait too long");
  // mailbox 0 receive raises transfer request
  a_dtc_trigger: assert property (@(posedge ref_clk_i) disable iff (ctl_rst)
    mb0_rx_evt && imr_q[1] |=> dtc_req_o)
    else $error("transfer request missing");
  c_mb0_rx: cover property (@(posedge ref_clk_i) dtc_req_o);
  c_mbx_wait: cover property (@(posedge ref_clk_i) wcnt_q == 3'(cnh_pkg::STORE_WAIT_MAX));
  c_write_refused: cover property (@(posedge ref_clk_i) refused_w);
endmodule // cnh_top

// [logic/cnh_pkg.sv]
// Functional notes
// - clock gated off until standby control releases
// - power-on or module stop resets all registers; mailbox data is kept
// - soft reset clears all but itself
// - reset initialization sets reset/config flag
// - reset clears only message control one
// - bus sleep stops most internal clocks
// - mailbox access during store waits 0-5
// - mailbox 0 receive triggers transfer controller
package cnh_pkg;
  localparam logic [11:0] STBCR_OFS = 12'h000;
  localparam logic [11:0] MCR_OFS = 12'h004;
  localparam logic [11:0] GSR_OFS = 12'h008;
  localparam logic [11:0] IRR_OFS = 12'h00C;
  localparam logic [11:0] IMR_OFS = 12'h010;
  localparam logic [11:0] RXSIM_OFS = 12'h014;
  localparam logic [11:0] MBX_BASE = 12'h100;
  localparam int MBX_WORDS = 8;
  localparam int MBX_COUNT = 4;
  localparam int MCR_SOFT_RESET_BIT = 0;
  localparam int MCR_CONFIG_BIT = 1;
  localparam int MCR_SLEEP_BIT = 5;
  localparam int STBCR_STOP_BIT = 0;
  localparam int IRR_RESET_CFG_BIT = 0;
  localparam int IRR_MB0_RX_BIT = 1;
  localparam int IRR_REFUSED_BIT = 2;
  localparam logic [31:0] STBCR_RESET = 32'h0000_0001;
  localparam logic [31:0] MCR_RESET = 32'h0000_0002;
  localparam logic [31:0] IMR_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
  localparam int STORE_WAIT_MAX = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [logic/cnh_mbx_ram.sv]
`timescale 1ns/1ps
// mailbox storage; contents survive every reset except message control one, only read data register resets
module cnh_mbx_ram #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // cnh_mbx_ram

// [dv/cnh_can_node.sv]
`timescale 1ns/1ps
module cnh_can_node (
  input wire logic ref_clk_i,
  input wire logic send_i,
  input wire logic [1:0] mbx_i,
  input wire logic [31:0] word_i,
  input wire logic done_i,
  output logic rx_store_o,
  output logic [1:0] rx_mbx_o,
  output logic [31:0] rx_word_o
);
  logic busy_q;
  initial begin
    rx_store_o = 1'b0;
    rx_mbx_o = 2'h0;
    rx_word_o = 32'h0;
    busy_q = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    rx_store_o <= send_i;
    if (send_i) begin
      busy_q <= 1'b1;
      rx_mbx_o <= mbx_i;
      rx_word_o <= word_i;
    end else if (busy_q && done_i === 1'b1) begin
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      rx_word_o <= ~rx_word_o;
    end
  end
endmodule // cnh_can_node

// [dv/can_controller_housekeeping_tb_top.sv]
`timescale 1ns/1ps
module can_controller_housekeeping_tb_top;
  logic ref_clk_i, srst_i, awv, wv, brdy, arv, rrdy, send;
  logic [11:0] awa, ara;
  logic [31:0] wd, word, rdat;
  logic [1:0] mbx, bresp, rresp, rxm;
  logic awr, wr_r, bv, arr, rv, rxs, done, cken, crst, data_transfer_controller, irq;
  logic [31:0] rxw;
  logic [31:0] mem [32];
  int fail_count, checks_done, cyc, dtc_n, done_n, seed, n;

  always #20 ref_clk_i = ~ref_clk_i;

  cnh_top u_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .rx_store_i(rxs), .rx_mbx_i(rxm), .rx_word_i(rxw), .rx_store_done_o(done),
    .core_clk_en_o(cken), .comm_rst_o(crst), .dtc_req_o(data_transfer_controller), .irq_o(irq)
  );

  cnh_can_node u_node (
    .ref_clk_i(ref_clk_i), .send_i(send), .mbx_i(mbx), .word_i(word), .done_i(done),
    .rx_store_o(rxs), .rx_mbx_o(rxm), .rx_word_o(rxw)
  );

  task automatic finish_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (data_transfer_controller === 1'b1) dtc_n <= dtc_n + 1;
    if (done === 1'b1) done_n <= done_n + 1;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      k++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_r === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && k < 200);
    brdy <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      k++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && k < 200);
    rrdy <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdat & m, e);
  endtask

  task automatic chk_mem;
    for (int i = 0; i < 32; i++) begin
      rd(cnh_pkg::MBX_BASE + 12'(4 * i), '1, mem[i], cnh_pkg::RESP_OKAY);
    end
  endtask

  task automatic frame(input logic [1:0] m);
    int d0, t0;
    d0 = done_n;
    t0 = dtc_n;
    @(posedge ref_clk_i);
    send <= 1'b1;
    mbx <= m;
    word <= $random(seed);
    @(posedge ref_clk_i);
    send <= 1'b0;
    rd(cnh_pkg::MBX_BASE + 12'h048, '1, mem[18], cnh_pkg::RESP_OKAY);
    for (n = 0; n < 100 && done_n == d0; n++) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) mem[m * 8 + i] = word;
    repeat (2) @(posedge ref_clk_i);
    chk(32'(done_n - d0), 32'h1);
    chk(32'(dtc_n - t0), {31'h0, m == 2'h0});
  endtask

  initial begin
    ref_clk_i = 1'b0;
    srst_i = 1'b1;
    {awv, wv, brdy, arv, rrdy, send} = '0;
    awa = '0;
    ara = '0;
    wd = '0;
    word = '0;
    mbx = '0;
    {fail_count, checks_done, cyc, dtc_n, done_n} = '0;
    seed = 32'h839f;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, cken}, 32'h0);
    chk({31'h0, crst}, 32'h1);
    rd(cnh_pkg::STBCR_OFS, '1, cnh_pkg::STBCR_RESET, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::MCR_OFS, '1, 32'h0, cnh_pkg::RESP_SLVERR);
    wr(cnh_pkg::STBCR_OFS, 32'h0, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, cken}, 32'h1);
    rd(cnh_pkg::MCR_OFS, '1, cnh_pkg::MCR_RESET, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::IRR_OFS, 32'h1, 32'h1, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::IRR_OFS, 32'h1, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::IRR_OFS, 32'h1, 32'h0, cnh_pkg::RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      mem[i] = $random(seed);
      wr(cnh_pkg::MBX_BASE + 12'(4 * i), mem[i], cnh_pkg::RESP_OKAY);
    end
    chk_mem();
    rd(12'h0F0, '1, 32'h0, cnh_pkg::RESP_SLVERR);
    $display("test startup done");
    wr(cnh_pkg::IMR_OFS, 32'h4, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::MCR_OFS, 32'h22, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, cken}, 32'h0);
    rd(cnh_pkg::MBX_BASE, '1, 32'h0, cnh_pkg::RESP_SLVERR);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h1);
    rd(cnh_pkg::GSR_OFS, 32'h4, 32'h4, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::IRR_OFS, 32'h4, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(cnh_pkg::IMR_OFS, 32'h0, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::MBX_BASE, 32'h0, cnh_pkg::RESP_SLVERR);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(cnh_pkg::IRR_OFS, 32'h4, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::MCR_OFS, 32'h0, cnh_pkg::RESP_OKAY);
    $display("test sleep done");
    wr(cnh_pkg::IMR_OFS, 32'h2, cnh_pkg::RESP_OKAY);
    frame(2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(cnh_pkg::IRR_OFS, 32'h2, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    frame(2'h1);
    chk_mem();
    $display("test receive done");
    wr(cnh_pkg::MCR_OFS, 32'h1, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, crst}, 32'h1);
    wr(cnh_pkg::MCR_OFS, 32'h0, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::IMR_OFS, '1, cnh_pkg::IMR_RESET, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::IRR_OFS, 32'h1, 32'h1, cnh_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) mem[i * 8 + 7] = cnh_pkg::CTRL1_RESET;
    chk_mem();
    wr(cnh_pkg::IRR_OFS, 32'h1, cnh_pkg::RESP_OKAY);
    $display("test soft_reset done");
    wr(cnh_pkg::IMR_OFS, 32'h4, cnh_pkg::RESP_OKAY);
    wr(cnh_pkg::STBCR_OFS, 32'h1, cnh_pkg::RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, cken}, 32'h0);
    chk({31'h0, crst}, 32'h1);
    wr(cnh_pkg::MBX_BASE, 32'h0, cnh_pkg::RESP_SLVERR);
    wr(cnh_pkg::STBCR_OFS, 32'h0, cnh_pkg::RESP_OKAY);
    rd(cnh_pkg::IMR_OFS, '1, cnh_pkg::IMR_RESET, cnh_pkg::RESP_OKAY);
    chk_mem();
    $display("test module_stop done");
    finish_test();
  end
endmodule // can_controller_housekeeping_tb_top
